// ---- shared/mch_pkg.sv ----
package mch_pkg;
    // bus geometry
    localparam int DATA_W      = 8;     // full data bus width
    localparam int ADDR_W      = 6;     // multiplexed address bits
    localparam int LOC_N       = 64;    // addressable internal locations
    // fixed locations inside the device map
    localparam logic [5:0] ADDR_STATUS = 6'h07;  // status register
    localparam logic [5:0] ADDR_MCMD   = 6'h08;  // motor command register
    // status bit positions
    localparam int ST_LIMIT_BIT = 4;    // end-of-travel flag
    localparam int ST_HALT_BIT  = 5;    // halt flag
    localparam int ST_CFG_W     = 4;    // writable low status bits
    // reset values
    localparam logic [7:0] MCMD_RST   = 8'h80;  // bipolar zero
    localparam logic [7:0] STATUS_RST = 8'h00;
    // clock and timing
    localparam int CLK_PS      = 5000;  // 200 MHz period in ps
    localparam int T_CSOE_NS   = 200;   // read: cs rise to oe fall extra
    localparam int T_RC_NS     = 450;   // read: ale to ale extra
    localparam int CSOE_CYC    = 3 + (T_CSOE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RC_CYC      = 3 + (T_RC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SYNC_LO_CYC = 18;    // least sync low width in clocks
    localparam int FILT_N      = 3;     // encoder stable-edge count
    localparam int POS_W       = 24;    // position counter width
    localparam int TIMER_W     = 8;     // sample timer width
    localparam logic [7:0] TIMER_LOAD = 8'h3f;  // sample period reload
    localparam int HALT_STEP   = 1;     // deceleration per sample
    // controller modes
    typedef enum logic [1:0] {
        MCH_RESET = 2'b00,
        MCH_IDLE  = 2'b01,
        MCH_RUN   = 2'b10,
        MCH_IVEL  = 2'b11
    } mch_mode_t;
    // host sequencer states
    typedef enum logic [2:0] {
        MCH_H_IDLE = 3'b000,
        MCH_H_ALE  = 3'b001,
        MCH_H_CS   = 3'b010,
        MCH_H_OE   = 3'b011,
        MCH_H_GAP  = 3'b100
    } mch_hstate_t;
endpackage : mch_pkg

// ---- shared/mch_if.sv ----
`timescale 1ns/1ps
interface mch_if;
    logic       ale_n;     // address latch strobe
    logic       cs_n;      // chip select
    logic       rd_wr_n;   // 1 read, 0 write
    logic       oe_n;      // output enable
    logic [7:0] host_d;    // host drive of the bus
    logic       host_oe;   // host drives bus
    logic [7:0] dev_d;     // device drive of the bus
    logic       dev_oe;    // device drives bus
    logic       sync_n;    // sample-timer sync
    wire  [7:0] bus = dev_oe ? dev_d : host_d;  // resolved bus level
    modport dev  (input ale_n, cs_n, rd_wr_n, oe_n, host_d, host_oe,
                  sync_n, output dev_d, dev_oe);
    modport host (output ale_n, cs_n, rd_wr_n, oe_n, host_d, host_oe,
                  sync_n, input dev_d, dev_oe);
endinterface : mch_if

// ---- hdl/mch_host.sv ----
`timescale 1ns/1ps
// host end: one read or write per request, timed for the device
module mch_host (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    // link
    mch_if.host             bus,
    // user request
    input  wire logic       req_i,
    input  wire logic       rd_i,
    input  wire logic [5:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       sync_req_i,
    output logic            busy_o,
    output logic            done_o,
    output logic [7:0]      rdata_o
);
    mch_pkg::mch_hstate_t st_reg, st_next;
    logic [7:0] cnt_reg, cnt_next;     // phase counter
    logic       rd_reg, rd_next;       // latched direction
    logic [7:0] d_reg, d_next;         // bus drive value
    logic [7:0] rdat_reg, rdat_next;
    logic       done_reg, done_next;
    logic [4:0] sync_reg, sync_next;   // sync low counter
    logic       ale_reg, ale_next, cs_reg, cs_next, oe_reg, oe_next;
    logic       hoe_reg, hoe_next;
    logic       busy_reg;              // registered busy, no decode glitch

    // next-state for the access sequencer
    always_comb begin
        st_next = st_reg; cnt_next = cnt_reg; rd_next = rd_reg;
        d_next = d_reg; rdat_next = rdat_reg; done_next = 1'b0;
        ale_next = ale_reg; cs_next = cs_reg; oe_next = oe_reg;
        hoe_next = hoe_reg;
        sync_next = sync_reg;
        // hold sync low long enough to take effect
        if (sync_req_i && sync_reg == 5'h00) begin
            sync_next = 5'(mch_pkg::SYNC_LO_CYC); // R12
        end else if (sync_reg != 5'h00) begin
            sync_next = sync_reg - 5'h01;
        end
        case (st_reg)
            mch_pkg::MCH_H_IDLE: begin
                if (req_i) begin
                    // address phase on the low six bits
                    d_next = {2'b00, addr_i};              // R1
                    rd_next = rd_i; hoe_next = 1'b1;
                    ale_next = 1'b0; cnt_next = 8'h02;
                    st_next = mch_pkg::MCH_H_ALE;
                end
            end
            mch_pkg::MCH_H_ALE: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    ale_next = 1'b1;
                    // data phase, direction set before cs
                    d_next = wdata_i; hoe_next = !rd_reg; // R4
                    cs_next = 1'b0; cnt_next = 8'h02;
                    st_next = mch_pkg::MCH_H_CS;
                end
            end
            mch_pkg::MCH_H_CS: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    cs_next = 1'b1;
                    cnt_next = 8'(mch_pkg::CSOE_CYC);
                    st_next = mch_pkg::MCH_H_OE;
                end
            end
            mch_pkg::MCH_H_OE: begin
                // counter parks at zero while a read waits for the device
                if (cnt_reg != 8'h00) cnt_next = cnt_reg - 8'h01;
                hoe_next = 1'b0;
                if (!rd_reg && cnt_reg == 8'h01) begin
                    done_next = 1'b1; cnt_next = 8'(mch_pkg::RC_CYC);
                    st_next = mch_pkg::MCH_H_GAP;
                end else if (rd_reg && cnt_reg == 8'h01) begin
                    oe_next = 1'b0;                        // R7 R8
                end else if (rd_reg && cnt_reg == 8'h00 && bus.dev_oe) begin
                    // take the data only once the device drives the bus
                    rdat_next = bus.dev_d;
                    oe_next = 1'b1;
                    done_next = 1'b1;
                    cnt_next = 8'(mch_pkg::RC_CYC - mch_pkg::CSOE_CYC);
                    st_next = mch_pkg::MCH_H_GAP;          // R10
                end
            end
            mch_pkg::MCH_H_GAP: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg <= 8'h01) st_next = mch_pkg::MCH_H_IDLE;
            end
            default: st_next = mch_pkg::MCH_H_IDLE;
        endcase
    end

    // register stage
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            st_reg <= mch_pkg::MCH_H_IDLE; cnt_reg <= 8'h00;
            rd_reg <= 1'b0; d_reg <= 8'h00; rdat_reg <= 8'h00;
            done_reg <= 1'b0; sync_reg <= 5'h00; ale_reg <= 1'b1;
            cs_reg <= 1'b1; oe_reg <= 1'b1; hoe_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            st_reg <= st_next; cnt_reg <= cnt_next; rd_reg <= rd_next;
            d_reg <= d_next; rdat_reg <= rdat_next; done_reg <= done_next;
            sync_reg <= sync_next; ale_reg <= ale_next; cs_reg <= cs_next;
            oe_reg <= oe_next; hoe_reg <= hoe_next;
            busy_reg <= (st_next != mch_pkg::MCH_H_IDLE);
        end
    end

    assign bus.ale_n   = ale_reg;
    assign bus.cs_n    = cs_reg;
    assign bus.oe_n    = oe_reg;
    assign bus.rd_wr_n = rd_reg;
    assign bus.host_d  = d_reg;
    assign bus.host_oe = hoe_reg;
    assign bus.sync_n  = (sync_reg == 5'h00);
    assign busy_o  = busy_reg;
    assign done_o  = done_reg;
    assign rdata_o = rdat_reg;
endmodule : mch_host

// ---- hdl/mch_dev.sv ----
`timescale 1ns/1ps
// What this block does
// R1: low six bus bits carry address, then data
// R2: top two bits are data only
// R3: address strobe latches low six bits
// R4: read/write line sets transfer direction
// R5: write stores bus data at latched address
// R6: read copies location into output latch
// R7: output enable drives output latch onto bus
// R8: host waits three clocks plus 200 ns
// R9: read data valid within three clocks plus 300 ns
// R10: reads spaced three clocks plus 450 ns
// R11: motor command write reaches pins quickly
// R12: host holds sync low eighteen clocks
// R13: end-of-travel flag forces idle mode
// R14: end-of-travel idle zeroes motor command
// R15: end-of-travel flag readable in status
// R16: halt decelerates only in integral velocity
// R17: reset sets every register but the general locations, enters reset mode
// R18: reference pulse either polarity, commutator only
// R19: encoder gives two quadrature channels
// R20: sync low in idle holds timer zero
// R21: flags clear after pin high and status write
// R22: encoder level needs three stable edges
// R23: position counts up when B leads A
// R24: address latch holds until next strobe
module mch_dev (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    // link
    mch_if.dev               bus,
    // emergency and encoder pins
    input  wire logic        limit_n_i,
    input  wire logic        halt_n_i,
    input  wire logic        enc_a_i,
    input  wire logic        enc_b_i,
    input  wire logic        ref_pulse_i,
    input  wire logic        ref_high_i,   // 1: reference pulse active high
    // controller mode request from user side
    input  wire logic        mode_run_i,
    input  wire logic        mode_ivel_i,
    // outputs
    output logic [7:0]       motor_command_outputs_o,
    output logic             idle_o,
    output logic [23:0]      position_o,
    output logic             ref_mark_o
);
    mch_pkg::mch_mode_t mode_reg, mode_next;
    logic [7:0] mem [mch_pkg::LOC_N];   // internal locations
    logic [5:0] addr_reg, addr_next;    // address latch
    logic [7:0] olat_reg, olat_next;    // output latch
    logic       idle_reg;               // registered idle flag
    logic       cs_d_reg;               // chip select history for edges
    logic       drv_reg, drv_next;
    logic [7:0] mc_reg, mc_next;
    logic [7:0] st_reg, st_next;
    logic       lim_reg, lim_next, hlt_reg, hlt_next;
    logic [7:0] tmr_reg, tmr_next;
    logic [2:0] fa_reg, fb_reg, fi_reg; // three-edge shift filters
    logic       a_reg, b_reg, i_reg, a_next, b_next, i_next;
    logic [23:0] pos_reg, pos_next;
    logic       ref_reg, ref_next;
    logic       wr_ev, rd_ev, sample;

    // filter: new level only after three equal samples
    function automatic logic filt(input logic [2:0] h, input logic cur);
        filt = (h == 3'b111) ? 1'b1 : (h == 3'b000) ? 1'b0 : cur;
    endfunction : filt

    // chip select rising edge completes the access
    assign wr_ev  = !cs_d_reg && bus.cs_n && !bus.rd_wr_n;         // R4
    assign rd_ev  = !cs_d_reg && bus.cs_n &&  bus.rd_wr_n;
    assign sample = (tmr_reg == 8'h00);

    // next values for bus, flags, mode and encoder
    always_comb begin
        addr_next = addr_reg; olat_next = olat_reg; mc_next = mc_reg;
        st_next = st_reg; mode_next = mode_reg; tmr_next = tmr_reg;
        lim_next = lim_reg; hlt_next = hlt_reg;
        // latch only on strobe, hold otherwise
        if (!bus.ale_n) addr_next = bus.host_d[5:0];          // R1 R2 R3 R24
        // drive only while output enable is low
        drv_next = !bus.oe_n && bus.rd_wr_n;                  // R7
        if (rd_ev) begin
            // copy into latch, bus still not driven
            olat_next = (addr_reg == mch_pkg::ADDR_MCMD) ? mc_reg :
                        (addr_reg == mch_pkg::ADDR_STATUS) ? st_reg :
                        mem[addr_reg];                        // R6 R9
        end
        // status write clears flags once pin is high again
        if (wr_ev && addr_reg == mch_pkg::ADDR_STATUS) begin
            st_next[mch_pkg::ST_CFG_W-1:0] =
                bus.host_d[mch_pkg::ST_CFG_W-1:0];
            if (limit_n_i) lim_next = 1'b0;                   // R21
            if (halt_n_i)  hlt_next = 1'b0;
        end
        // set wins over clear
        if (!limit_n_i) lim_next = 1'b1;
        if (!halt_n_i)  hlt_next = 1'b1;
        st_next[mch_pkg::ST_LIMIT_BIT] = lim_next;            // R15
        st_next[mch_pkg::ST_HALT_BIT]  = hlt_next;
        if (wr_ev && addr_reg == mch_pkg::ADDR_MCMD)
            mc_next = bus.host_d;                             // R11
        // sample timer, cleared by sync in idle only
        if (mode_reg == mch_pkg::MCH_IDLE && !bus.sync_n)
            tmr_next = 8'h00;                                 // R20
        else if (sample) tmr_next = mch_pkg::TIMER_LOAD;
        else tmr_next = tmr_reg - 8'h01;
        // mode leaves idle for run or ivel only at control sample boundaries
        case (mode_reg)
            mch_pkg::MCH_RESET: mode_next = mch_pkg::MCH_IDLE;
            mch_pkg::MCH_IDLE: begin
                if (sample && !lim_reg && mode_ivel_i)
                    mode_next = mch_pkg::MCH_IVEL;
                else if (sample && !lim_reg && mode_run_i)
                    mode_next = mch_pkg::MCH_RUN;
            end
            mch_pkg::MCH_RUN, mch_pkg::MCH_IVEL: begin
                if (sample && hlt_reg && mode_reg == mch_pkg::MCH_IVEL &&
                    mc_reg != mch_pkg::MCMD_RST) begin
                    // step toward bipolar zero
                    mc_next = (mc_reg > mch_pkg::MCMD_RST) ?
                        mc_reg - 8'(mch_pkg::HALT_STEP) :
                        mc_reg + 8'(mch_pkg::HALT_STEP);      // R16
                end
            end
            default: mode_next = mch_pkg::MCH_RESET;
        endcase
        if (lim_reg && mode_reg != mch_pkg::MCH_RESET) begin
            mode_next = mch_pkg::MCH_IDLE;                    // R13
            if (mode_reg != mch_pkg::MCH_IDLE)
                mc_next = mch_pkg::MCMD_RST;                  // R14
        end
        // encoder filter and quadrature decode
        a_next = filt(fa_reg, a_reg);                         // R22
        b_next = filt(fb_reg, b_reg);
        i_next = filt(fi_reg, i_reg);
        pos_next = pos_reg;
        if ((a_next ^ a_reg) || (b_next ^ b_reg)) begin
            // b leads a when the new b differs from the old a
            if ((b_next ^ a_reg) != 1'b0) pos_next = pos_reg + 24'h1;
            else pos_next = pos_reg - 24'h1;                  // R19 R23
        end
        // reference mark for commutator only
        ref_next = (i_next ^ i_reg) && (i_next == ref_high_i); // R18
    end

    // registers; reset gives reset mode
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            mode_reg  <= mch_pkg::MCH_RESET;                  // R17
            idle_reg  <= 1'b0;
            addr_reg  <= 6'h00;
            olat_reg  <= 8'h00;
            drv_reg   <= 1'b0;
            cs_d_reg  <= 1'b1;
            mc_reg    <= mch_pkg::MCMD_RST;
            st_reg    <= mch_pkg::STATUS_RST;
            lim_reg   <= 1'b0;
            hlt_reg   <= 1'b0;
            tmr_reg   <= 8'h00;
            fa_reg    <= 3'h0;
            fb_reg    <= 3'h0;
            fi_reg    <= 3'h0;
            a_reg     <= 1'b0;
            b_reg     <= 1'b0;
            i_reg     <= 1'b0;
            pos_reg   <= 24'h0;
            ref_reg   <= 1'b0;
        end else begin
            mode_reg  <= mode_next;
            // registered so the idle pin never glitches on decode
            idle_reg  <= (mode_next == mch_pkg::MCH_IDLE);
            addr_reg  <= addr_next;
            olat_reg  <= olat_next;
            drv_reg   <= drv_next;
            cs_d_reg  <= bus.cs_n;
            mc_reg    <= mc_next;
            st_reg    <= st_next;
            lim_reg   <= lim_next;
            hlt_reg   <= hlt_next;
            tmr_reg   <= tmr_next;
            // three-sample history feeds the stable-level filter
            fa_reg    <= {fa_reg[1:0], enc_a_i};
            fb_reg    <= {fb_reg[1:0], enc_b_i};
            fi_reg    <= {fi_reg[1:0], ref_pulse_i};
            a_reg     <= a_next;
            b_reg     <= b_next;
            i_reg     <= i_next;
            pos_reg   <= pos_next;
            ref_reg   <= ref_next;
        end
    end

    // general locations; memory has no reset by design
    always_ff @(posedge mclk_i) begin
        if (wr_ev) mem[addr_reg] <= bus.host_d;               // R5
    end

    assign bus.dev_d  = olat_reg;
    assign bus.dev_oe = drv_reg;
    assign motor_command_outputs_o = mc_reg;
    assign idle_o     = idle_reg;
    assign position_o = pos_reg;
    assign ref_mark_o = ref_reg;
endmodule : mch_dev

// ---- verif/mch_checker.sv ----
`timescale 1ns/1ps
// watches the link between the host end and the device end
module mch_checker (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    // link signals
    input  wire logic       ale_n,
    input  wire logic       cs_n,
    input  wire logic       rd_wr_n,
    input  wire logic       oe_n,
    input  wire logic       host_oe,
    input  wire logic [7:0] dev_d,
    input  wire logic       dev_oe,
    input  wire logic       sync_n
);
    logic       cs_q;     // chip select one cycle ago
    logic       ale_q;    // strobe one cycle ago
    logic [7:0] cs_cnt;   // cycles since chip select rose
    logic [7:0] ale_cnt;  // cycles since the strobe fell
    logic [7:0] lo_cnt;   // cycles sync has been low
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // counters saturate so a long idle never wraps into a false pass
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            cs_q    <= 1'b1;
            ale_q   <= 1'b1;
            cs_cnt  <= 8'hff;
            ale_cnt <= 8'hff;
            lo_cnt  <= 8'h00;
        end else begin
            cs_q    <= cs_n;
            ale_q   <= ale_n;
            cs_cnt  <= (cs_n && !cs_q) ? 8'h01 :
                       cs_cnt + {7'h0, cs_cnt != 8'hff};
            ale_cnt <= (!ale_n && ale_q) ? 8'h01 :
                       ale_cnt + {7'h0, ale_cnt != 8'hff};
            lo_cnt  <= sync_n ? 8'h00 : lo_cnt + {7'h0, lo_cnt != 8'hff};
        end
    end
    // output enable seen low on two edges in a row
    sequence oe_held;
        $fell(oe_n) ##1 !oe_n;
    endsequence
    addr_phase_a: assert property (!ale_n |-> host_oe && !dev_oe && cs_n)
        else $error("address phase bus ownership wrong");
    no_contend_a: assert property (!(dev_oe && host_oe))
        else $error("both ends drive the bus");
    rw_stable_a: assert property (!cs_n && !$past(cs_n) |-> $stable(rd_wr_n))
        else $error("direction changed inside chip select");
    oe_drive_a: assert property (oe_held |-> dev_oe)
        else $error("device not driving under output enable");
    data_stable_a: assert property (dev_oe && $past(dev_oe) |-> $stable(dev_d))
        else $error("read data moved while driven");
    oe_wait_a: assert property ($fell(oe_n) |-> cs_cnt >= mch_pkg::CSOE_CYC)
        else $error("output enable too soon after chip select");
    data_valid_a: assert property ($rose(dev_oe) |-> cs_cnt <= 63)
        else $error("read data later than allowed");
    read_gap_a: assert property ($fell(ale_n) |-> ale_cnt >= mch_pkg::RC_CYC)
        else $error("accesses spaced too closely");
    sync_width_a: assert property ($rose(sync_n) |-> lo_cnt >= mch_pkg::SYNC_LO_CYC)
        else $error("sync low pulse too short");
endmodule : mch_checker

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
// drives the user sides of both ends and compares with a simple model
module tb_top;
    logic mclk_i, reset_n_i, req_i, rd_i, sync_req_i, busy_o, done_o;
    logic limit_n_i, halt_n_i, enc_a_i, enc_b_i, ref_pulse_i, ref_high_i;
    logic mode_run_i, mode_ivel_i, idle_o, ref_mark_o, cs_q;
    logic [5:0]  addr_i;
    logic [7:0]  wdata_i, rdata_o, motor_command_outputs_o, mc_q, bus_last;
    logic [23:0] position_o;
    logic [31:0] seed;                  // random source state
    int n_errors, cmp_count, cyc, marks, lo_run, sync_lo, cs_t, mc_t;
    int mem [64];                       // model of the storage locations
    mch_if link ();
    mch_host mch_host_inst (.mclk_i, .reset_n_i, .bus(link), .req_i, .rd_i,
        .addr_i, .wdata_i, .sync_req_i, .busy_o, .done_o, .rdata_o);
    mch_dev mch_dev_inst (.mclk_i, .reset_n_i, .bus(link), .limit_n_i,
        .halt_n_i, .enc_a_i, .enc_b_i, .ref_pulse_i, .ref_high_i,
        .mode_run_i, .mode_ivel_i, .motor_command_outputs_o, .idle_o,
        .position_o, .ref_mark_o);
    mch_checker mch_checker_inst (.mclk_i, .reset_n_i, .ale_n(link.ale_n),
        .cs_n(link.cs_n), .rd_wr_n(link.rd_wr_n), .oe_n(link.oe_n),
        .host_oe(link.host_oe), .dev_d(link.dev_d), .dev_oe(link.dev_oe),
        .sync_n(link.sync_n));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic finish_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // one host access, waits for completion and the spacing gap
    task automatic acc(input logic rd, input logic [5:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        @(negedge mclk_i);
        {rd_i, addr_i, wdata_i, req_i} = {rd, a, d, 1'b1};
        @(negedge mclk_i);
        req_i = 1'b0;
        for (n = 0; n < 400 && done_o !== 1'b1; n++) @(negedge mclk_i);
        q = rdata_o;
        for (n = 0; n < 400 && busy_o !== 1'b0; n++) @(negedge mclk_i);
    endtask : acc
    task automatic wait_idle(input logic v);
        for (int n = 0; n < 300 && idle_o !== v; n++) @(negedge mclk_i);
    endtask : wait_idle
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    // wire monitor: read data, reference marks, sync width, command timing
    always @(posedge mclk_i) begin
        cyc++;
        if (ref_mark_o === 1'b1) marks++;
        if (link.dev_oe === 1'b1) bus_last = link.bus;
        if (link.sync_n === 1'b0) lo_run++;
        else if (lo_run != 0) {sync_lo, lo_run} = {lo_run, 0};
        if (link.cs_n === 1'b1 && cs_q === 1'b0) cs_t = cyc;
        if (motor_command_outputs_o !== mc_q) mc_t = cyc;
        {cs_q, mc_q} = {link.cs_n, motor_command_outputs_o};
        if (cyc == 20000) begin
            n_errors++;          // hang cut short
            finish_test();
        end
    end
    initial begin : main
        logic [7:0] q;
        int a, m, qa[$];
        logic [1:0] fwd [4];
        fwd = '{2'b01, 2'b11, 2'b10, 2'b00};  // {a, b}: b leads a
        {reset_n_i, req_i, rd_i, addr_i, wdata_i, sync_req_i} = '0;
        {limit_n_i, halt_n_i, enc_a_i, enc_b_i} = 4'b1100;
        {ref_pulse_i, ref_high_i, mode_run_i, mode_ivel_i} = 4'b1000;
        seed = 32'h2100a04e;
        repeat (4) @(negedge mclk_i);
        reset_n_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        `CHK("mc_rst", mch_pkg::MCMD_RST, motor_command_outputs_o);
        `CHK("idle_rst", 1, idle_o);
        `CHK("pos_rst", 0, position_o);
        // random writes then read-back, top bits carry data only
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            a = 16 + seed[4:0];
            mem[a] = seed[15:8];
            qa.push_back(a);
            acc(1'b0, a[5:0], seed[15:8], q);
        end
        foreach (qa[i]) begin
            acc(1'b1, qa[i][5:0], 8'h00, q);
            `CHK("rdata", mem[qa[i]], q);
            `CHK("bus_data", mem[qa[i]], bus_last);
        end
        acc(1'b0, mch_pkg::ADDR_MCMD, 8'h5a, q);
        `CHK("mc_write", 8'h5a, motor_command_outputs_o);
        `CHK("mc_time", 1, (mc_t - cs_t) <= 3);
        // end-of-travel while running
        mode_run_i = 1'b1;
        wait_idle(1'b0);
        `CHK("run_mode", 0, idle_o);
        // halt must leave the command alone outside integral velocity
        halt_n_i = 1'b0;
        repeat (150) @(negedge mclk_i);
        `CHK("halt_run", 8'h5a, motor_command_outputs_o);
        limit_n_i = 1'b0;
        wait_idle(1'b1);
        `CHK("lim_idle", 1, idle_o);
        `CHK("lim_mc", mch_pkg::MCMD_RST, motor_command_outputs_o);
        acc(1'b1, mch_pkg::ADDR_STATUS, 8'h00, q);
        `CHK("lim_flag", 1, q[4]);
        `CHK("halt_flag", 1, q[5]);
        {mode_run_i, limit_n_i, halt_n_i} = 3'b011;
        acc(1'b1, mch_pkg::ADDR_STATUS, 8'h00, q);
        `CHK("flag_kept", 1, q[4]);
        acc(1'b0, mch_pkg::ADDR_STATUS, 8'hf3, q);
        acc(1'b1, mch_pkg::ADDR_STATUS, 8'h00, q);
        `CHK("flag_clr", 8'h03, q[5:0]);
        // halt in integral velocity steps the command to bipolar zero
        acc(1'b0, mch_pkg::ADDR_MCMD, 8'h83, q);
        mode_ivel_i = 1'b1;
        wait_idle(1'b0);
        halt_n_i = 1'b0;
        repeat (260) @(negedge mclk_i);
        `CHK("halt_stop", mch_pkg::MCMD_RST, motor_command_outputs_o);
        {mode_ivel_i, halt_n_i, limit_n_i} = 3'b010;
        wait_idle(1'b1);
        `CHK("lim_ivel", 1, idle_o);
        limit_n_i = 1'b1;
        // quadrature forward, backward, then a short glitch
        for (int i = 0; i < 8; i++) begin
            {enc_a_i, enc_b_i} = (i < 4) ? fwd[i] : fwd[(10 - i) % 4];
            repeat (6) @(negedge mclk_i);
            if (i == 3) `CHK("pos_up", 24'd4, position_o);
        end
        enc_a_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        `CHK("pos_glitch", 24'd0, position_o);
        enc_a_i = 1'b0;
        repeat (8) @(negedge mclk_i);
        `CHK("pos_back", 24'd0, position_o);
        // reference pulse in both polarities
        for (int p = 0; p < 2; p++) begin
            {ref_high_i, ref_pulse_i} = {p[0], ~p[0]};
            repeat (10) @(negedge mclk_i);
            m = marks;
            ref_pulse_i = p[0];
            repeat (8) @(negedge mclk_i);
            ref_pulse_i = ~p[0];
            repeat (10) @(negedge mclk_i);
            `CHK("ref_mark", m + 1, marks);
        end
        sync_req_i = 1'b1;
        @(negedge mclk_i);
        sync_req_i = 1'b0;
        repeat (40) @(negedge mclk_i);
        `CHK("sync_low", 1, sync_lo >= 18);
        finish_test();
    end
endmodule : tb_top
